// >>> logic/fpcx_pkg.sv
`default_nettype none
package fpcx_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   localparam int FLAG_W = 6;
   localparam int SIMD_W = 13;
   localparam int EXP_W = 18;
   localparam int SIMD_FLAG_LSB = 0;
   localparam int SIMD_MASK_LSB = 7;
   localparam int FLAG_INV = 0;
   localparam int FLAG_DEN = 1;
   localparam int FLAG_ZDIV = 2;
   localparam int FLAG_OVF = 3;
   localparam int FLAG_UNF = 4;
   localparam int FLAG_PREC = 5;
   localparam logic [ADDR_W-1:0] ADDR_STK_STATUS = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_STK_CTRL = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_SIMD_CSR = 12'h008;
   localparam logic [FLAG_W-1:0] STK_STATUS_RST = 6'h00;
   localparam logic [FLAG_W-1:0] STK_CTRL_RST = 6'h3F;
   localparam logic [SIMD_W-1:0] SIMD_CSR_RST = 13'h1F80;
   localparam logic [SIMD_W-1:0] SIMD_CSR_WMASK = 13'h1FBF;
   // Unbiased exponent of the rounded, normalised result
   localparam logic signed [EXP_W-1:0] OVF_EXP_SGL = 18'sh00080;
   localparam logic signed [EXP_W-1:0] OVF_EXP_DBL = 18'sh00400;
   localparam logic signed [EXP_W-1:0] OVF_EXP_EXT = 18'sh04000;
   localparam logic signed [EXP_W-1:0] TINY_EXP_SGL = -18'sh0007E;
   localparam logic signed [EXP_W-1:0] TINY_EXP_DBL = -18'sh003FE;
   localparam logic signed [EXP_W-1:0] TINY_EXP_EXT = -18'sh03FFE;

   typedef enum logic [1:0] {FMT_SINGLE, FMT_DOUBLE, FMT_EXTENDED} fpcx_fmt_e;
   typedef enum logic [1:0] {RM_NEAREST, RM_DOWN, RM_UP, RM_ZERO} fpcx_rmode_e;
   typedef enum logic {UNIT_STACK, UNIT_SIMD} fpcx_unit_e;
   typedef enum logic [2:0] {
      KIND_NONE, KIND_ROUNDED, KIND_DENORM, KIND_INF, KIND_MAX_FINITE, KIND_BIASED
   } fpcx_kind_e;

   typedef struct packed {
      logic valid;
      fpcx_unit_e unit;
      fpcx_fmt_e fmt;
      fpcx_rmode_e rmode;
      logic sign;
      logic zero;
      logic inexact;
      logic dest_mem;
      logic signed [EXP_W-1:0] exp;
   } fpcx_req_s;

   typedef struct packed {
      logic valid;
      fpcx_kind_e kind;
      logic sign;
      logic handler;
      fpcx_unit_e unit;
   } fpcx_res_s;

   typedef struct packed {
      logic [FLAG_W-1:0] stk_status;
      logic [FLAG_W-1:0] stk_ctrl;
      logic [SIMD_W-1:0] simd_csr;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
      fpcx_res_s res;
   } fpcx_state_s;
endpackage : fpcx_pkg
`default_nettype wire

// >>> logic/fpcx_unit.sv
`timescale 1ns/100ps
`default_nettype none
module fpcx_unit (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [fpcx_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [fpcx_pkg::DATA_W-1:0] pwdata_i,
   output logic pready_o,
   output logic [fpcx_pkg::DATA_W-1:0] prdata_o,
   output logic pslverr_o,
   input wire fpcx_pkg::fpcx_req_s req_i,
   output fpcx_pkg::fpcx_res_s res_o
);
   localparam fpcx_pkg::fpcx_state_s ST_RST = '{
      stk_status: fpcx_pkg::STK_STATUS_RST,
      stk_ctrl: fpcx_pkg::STK_CTRL_RST,
      simd_csr: fpcx_pkg::SIMD_CSR_RST,
      prdata: '0,
      pslverr: 1'b0,
      res: '0
   };

   fpcx_pkg::fpcx_state_s s_q;
   fpcx_pkg::fpcx_state_s s_d;

   function automatic logic signed [fpcx_pkg::EXP_W-1:0] ovf_thr(fpcx_pkg::fpcx_fmt_e f);
      case (f)
         fpcx_pkg::FMT_SINGLE: ovf_thr = fpcx_pkg::OVF_EXP_SGL;
         fpcx_pkg::FMT_DOUBLE: ovf_thr = fpcx_pkg::OVF_EXP_DBL;
         default: ovf_thr = fpcx_pkg::OVF_EXP_EXT;
      endcase
   endfunction : ovf_thr

   function automatic logic signed [fpcx_pkg::EXP_W-1:0] tiny_thr(fpcx_pkg::fpcx_fmt_e f);
      case (f)
         fpcx_pkg::FMT_SINGLE: tiny_thr = fpcx_pkg::TINY_EXP_SGL;
         fpcx_pkg::FMT_DOUBLE: tiny_thr = fpcx_pkg::TINY_EXP_DBL;
         default: tiny_thr = fpcx_pkg::TINY_EXP_EXT;
      endcase
   endfunction : tiny_thr

   // Masked overflow answer chosen by rounding direction and sign
   function automatic fpcx_pkg::fpcx_kind_e ovf_default(fpcx_pkg::fpcx_rmode_e rm,
                                                       logic neg);
      case (rm)
         fpcx_pkg::RM_NEAREST: ovf_default = fpcx_pkg::KIND_INF;
         fpcx_pkg::RM_DOWN: ovf_default = neg ? fpcx_pkg::KIND_INF
                                              : fpcx_pkg::KIND_MAX_FINITE;
         fpcx_pkg::RM_UP: ovf_default = neg ? fpcx_pkg::KIND_MAX_FINITE
                                            : fpcx_pkg::KIND_INF;
         default: ovf_default = fpcx_pkg::KIND_MAX_FINITE;
      endcase
   endfunction : ovf_default

   logic ovf_w;
   logic tiny_w;
   logic [fpcx_pkg::FLAG_W-1:0] mask_w;
   logic [fpcx_pkg::FLAG_W-1:0] cur_flags_w;
   logic [fpcx_pkg::FLAG_W-1:0] q_flags_w;
   logic apb_wr_w;
   logic wr_stk_w;
   logic wr_simd_w;
   logic wr_flag_w;
   logic is_simd_w;
   logic m_o_w;
   logic m_u_w;
   logic m_p_w;
   logic msk_exc_w;
   logic unm_exc_w;
   logic [fpcx_pkg::FLAG_W-1:0] simd_flags_w;

   // Zero carries no exponent, so it can never be tiny or too large
   assign ovf_w = !req_i.zero && (req_i.exp >= ovf_thr(req_i.fmt));
   assign tiny_w = !req_i.zero && (req_i.exp < tiny_thr(req_i.fmt));
   assign is_simd_w = (req_i.unit == fpcx_pkg::UNIT_SIMD);
   assign mask_w = is_simd_w ? s_q.simd_csr[fpcx_pkg::SIMD_MASK_LSB +: fpcx_pkg::FLAG_W]
                             : s_q.stk_ctrl;
   assign cur_flags_w = is_simd_w ? s_q.simd_csr[fpcx_pkg::SIMD_FLAG_LSB +: fpcx_pkg::FLAG_W]
                                  : s_q.stk_status;
   assign q_flags_w = (res_o.unit == fpcx_pkg::UNIT_SIMD)
                      ? s_q.simd_csr[fpcx_pkg::SIMD_FLAG_LSB +: fpcx_pkg::FLAG_W]
                      : s_q.stk_status;
   assign m_o_w = mask_w[fpcx_pkg::FLAG_OVF];
   assign m_u_w = mask_w[fpcx_pkg::FLAG_UNF];
   assign m_p_w = mask_w[fpcx_pkg::FLAG_PREC];
   assign apb_wr_w = psel_i && penable_i && pwrite_i;
   assign wr_stk_w = apb_wr_w && (paddr_i == fpcx_pkg::ADDR_STK_STATUS);
   assign wr_simd_w = apb_wr_w && (paddr_i == fpcx_pkg::ADDR_SIMD_CSR);
   assign wr_flag_w = is_simd_w ? wr_simd_w : wr_stk_w;
   assign msk_exc_w = (ovf_w && m_o_w) || (tiny_w && m_u_w);
   assign unm_exc_w = (ovf_w && !m_o_w) || (tiny_w && !m_u_w);
   assign simd_flags_w = s_q.simd_csr[fpcx_pkg::SIMD_FLAG_LSB +: fpcx_pkg::FLAG_W];

   // Zero wait states; read data is captured in the setup cycle
   assign pready_o = 1'b1;
   assign prdata_o = s_q.prdata;
   assign pslverr_o = s_q.pslverr && psel_i && penable_i;
   assign res_o = s_q.res;

   always_comb begin
      logic [fpcx_pkg::FLAG_W-1:0] ev;
      logic hand;
      logic masked;
      fpcx_pkg::fpcx_kind_e kind;
      ev = '0;
      hand = 1'b0;
      masked = 1'b0;
      kind = fpcx_pkg::KIND_ROUNDED;
      s_d = s_q;

      if (apb_wr_w) begin
         case (paddr_i)
            fpcx_pkg::ADDR_STK_STATUS: s_d.stk_status = pwdata_i[fpcx_pkg::FLAG_W-1:0];
            fpcx_pkg::ADDR_STK_CTRL: s_d.stk_ctrl = pwdata_i[fpcx_pkg::FLAG_W-1:0];
            fpcx_pkg::ADDR_SIMD_CSR: begin
               s_d.simd_csr = pwdata_i[fpcx_pkg::SIMD_W-1:0] & fpcx_pkg::SIMD_CSR_WMASK;
            end
            default: ;
         endcase
      end

      if (!req_i.valid) begin
         kind = fpcx_pkg::KIND_NONE;
      end else if (ovf_w || tiny_w) begin
         masked = ovf_w ? m_o_w : m_u_w;
         if (masked) begin
            if (ovf_w) begin
               ev[fpcx_pkg::FLAG_OVF] = 1'b1;
               kind = ovf_default(req_i.rmode, req_i.sign);
            end else begin
               // Exact tiny results stay silent when masked
               ev[fpcx_pkg::FLAG_UNF] = req_i.inexact;
               kind = fpcx_pkg::KIND_DENORM;
            end
            if (req_i.inexact) begin
               ev[fpcx_pkg::FLAG_PREC] = 1'b1;
               hand = !m_p_w;
            end
         end else begin
            if (ovf_w) begin
               ev[fpcx_pkg::FLAG_OVF] = 1'b1;
            end else begin
               ev[fpcx_pkg::FLAG_UNF] = 1'b1;
            end
            hand = 1'b1;
            // Vector side must leave operands intact for the handler
            kind = is_simd_w ? fpcx_pkg::KIND_NONE : fpcx_pkg::KIND_BIASED;
            if (req_i.inexact && !req_i.dest_mem) begin
               ev[fpcx_pkg::FLAG_PREC] = 1'b1;
            end
         end
      end else if (req_i.inexact) begin
         ev[fpcx_pkg::FLAG_PREC] = 1'b1;
         hand = !m_p_w;
      end

      // Hardware events win over a clear written in the same cycle
      if (is_simd_w) begin
         s_d.simd_csr[fpcx_pkg::SIMD_FLAG_LSB +: fpcx_pkg::FLAG_W] =
            s_d.simd_csr[fpcx_pkg::SIMD_FLAG_LSB +: fpcx_pkg::FLAG_W] | ev;
      end else begin
         s_d.stk_status = s_d.stk_status | ev;
      end

      s_d.res.valid = req_i.valid;
      s_d.res.kind = kind;
      s_d.res.sign = req_i.sign;
      s_d.res.handler = hand;
      s_d.res.unit = req_i.unit;

      if (psel_i && !penable_i) begin
         s_d.pslverr = 1'b0;
         case (paddr_i)
            fpcx_pkg::ADDR_STK_STATUS: s_d.prdata = fpcx_pkg::DATA_W'(s_q.stk_status);
            fpcx_pkg::ADDR_STK_CTRL: s_d.prdata = fpcx_pkg::DATA_W'(s_q.stk_ctrl);
            fpcx_pkg::ADDR_SIMD_CSR: s_d.prdata = fpcx_pkg::DATA_W'(s_q.simd_csr);
            default: begin
               s_d.prdata = '0;
               s_d.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_ovf;
      req_i.valid && ovf_w;
   endsequence
   sequence s_tiny;
      req_i.valid && tiny_w;
   endsequence
   sequence s_plain_inexact;
      req_i.valid && req_i.inexact && !ovf_w && !tiny_w;
   endsequence
   sequence s_plain_exact;
      req_i.valid && !req_i.inexact && !ovf_w && !tiny_w;
   endsequence
   sequence s_masked_exc;
      req_i.valid && msk_exc_w;
   endsequence
   sequence s_unmasked_exc;
      req_i.valid && unm_exc_w;
   endsequence

   AST_OVF_FLAG: assert property (s_ovf |=> q_flags_w[fpcx_pkg::FLAG_OVF])
      else $error("overflow flag not set");
   AST_OVF_MASKED: assert property (
      s_ovf ##0 (m_o_w && (m_p_w || !req_i.inexact)) |=>
      res_o.valid && !res_o.handler &&
      (res_o.kind inside {fpcx_pkg::KIND_INF, fpcx_pkg::KIND_MAX_FINITE}))
      else $error("masked overflow default wrong");
   AST_OVF_RN_INF: assert property (
      s_ovf ##0 (m_o_w && req_i.rmode == fpcx_pkg::RM_NEAREST) |=>
      res_o.kind == fpcx_pkg::KIND_INF)
      else $error("nearest overflow not infinity");
   AST_OVF_RZ_MAX: assert property (
      s_ovf ##0 (m_o_w && req_i.rmode == fpcx_pkg::RM_ZERO) |=>
      res_o.kind == fpcx_pkg::KIND_MAX_FINITE)
      else $error("toward zero overflow not largest finite");
   AST_OVF_DIRECTED: assert property (
      s_ovf ##0 (m_o_w && req_i.rmode inside {fpcx_pkg::RM_DOWN, fpcx_pkg::RM_UP}) |=>
      (res_o.kind == fpcx_pkg::KIND_MAX_FINITE) ==
      (res_o.sign == ($past(req_i.rmode) == fpcx_pkg::RM_UP)))
      else $error("directed overflow default wrong");
   AST_OVF_UNMASKED: assert property (
      s_ovf ##0 !m_o_w |=> res_o.handler &&
      res_o.kind == ((res_o.unit == fpcx_pkg::UNIT_SIMD) ? fpcx_pkg::KIND_NONE
                                                         : fpcx_pkg::KIND_BIASED))
      else $error("unmasked overflow response wrong");

   // Checks that flags stay clear or unchanged skip cycles with a software write, which may change bits
   AST_TINY_EXACT: assert property (
      s_tiny ##0 (m_u_w && !req_i.inexact && !wr_flag_w &&
      !cur_flags_w[fpcx_pkg::FLAG_UNF]) |=>
      !q_flags_w[fpcx_pkg::FLAG_UNF] && res_o.kind == fpcx_pkg::KIND_DENORM)
      else $error("exact tiny result flagged");
   AST_TINY_INEXACT: assert property (
      s_tiny ##0 (m_u_w && req_i.inexact) |=>
      q_flags_w[fpcx_pkg::FLAG_UNF] && res_o.kind == fpcx_pkg::KIND_DENORM)
      else $error("inexact tiny result not flagged");
   AST_TINY_UNMASKED: assert property (
      s_tiny ##0 !m_u_w |=> res_o.handler && q_flags_w[fpcx_pkg::FLAG_UNF] &&
      res_o.kind == ((res_o.unit == fpcx_pkg::UNIT_SIMD) ? fpcx_pkg::KIND_NONE
                                                         : fpcx_pkg::KIND_BIASED))
      else $error("unmasked underflow not reported");
   AST_ZERO_QUIET: assert property (
      req_i.valid && req_i.zero && !req_i.inexact && !wr_flag_w |=>
      res_o.kind == fpcx_pkg::KIND_ROUNDED && !res_o.handler &&
      q_flags_w == $past(cur_flags_w))
      else $error("zero result raised an exception");

   AST_INEXACT_FLAG: assert property (
      req_i.valid && req_i.inexact && !(unm_exc_w && req_i.dest_mem) |=>
      q_flags_w[fpcx_pkg::FLAG_PREC])
      else $error("inexact result not flagged");
   AST_EXACT_QUIET: assert property (
      s_plain_exact ##0 !wr_flag_w |=> res_o.kind == fpcx_pkg::KIND_ROUNDED &&
      !res_o.handler && q_flags_w == $past(cur_flags_w))
      else $error("exact result raised an exception");
   AST_PREC_MASKED: assert property (
      s_plain_inexact ##0 m_p_w |=>
      q_flags_w[fpcx_pkg::FLAG_PREC] && !res_o.handler &&
      res_o.kind == fpcx_pkg::KIND_ROUNDED)
      else $error("masked inexact response wrong");
   AST_PREC_UNMASKED: assert property (
      s_plain_inexact ##0 !m_p_w |=>
      q_flags_w[fpcx_pkg::FLAG_PREC] && res_o.handler &&
      res_o.kind == fpcx_pkg::KIND_ROUNDED)
      else $error("unmasked inexact response wrong");
   AST_MASKED_EXC_PREC: assert property (
      s_masked_exc ##0 req_i.inexact |=> q_flags_w[fpcx_pkg::FLAG_PREC] &&
      (res_o.handler != $past(m_p_w)))
      else $error("inexact with masked exception mishandled");
   AST_UNMASKED_REG_PREC: assert property (
      s_unmasked_exc ##0 (req_i.inexact && !req_i.dest_mem) |=>
      q_flags_w[fpcx_pkg::FLAG_PREC] && res_o.handler)
      else $error("inexact with unmasked exception not flagged");
   AST_MEM_IGNORE: assert property (
      s_unmasked_exc ##0 (req_i.dest_mem && !wr_flag_w &&
      !cur_flags_w[fpcx_pkg::FLAG_PREC]) |=>
      !q_flags_w[fpcx_pkg::FLAG_PREC] && res_o.handler)
      else $error("inexact not ignored on memory store");

   AST_STICKY: assert property (
      !wr_stk_w |=> (s_q.stk_status & $past(s_q.stk_status)) == $past(s_q.stk_status))
      else $error("sticky flag lost");
   AST_SIMD_STICKY: assert property (
      !wr_simd_w |=> (simd_flags_w & $past(simd_flags_w)) == $past(simd_flags_w))
      else $error("sticky vector flag lost");
   AST_STACK_ISOLATED: assert property (
      req_i.valid && is_simd_w && !wr_stk_w |=> s_q.stk_status == $past(s_q.stk_status))
      else $error("vector event touched stack flags");
   AST_SIMD_ISOLATED: assert property (
      req_i.valid && !is_simd_w && !wr_simd_w |=> simd_flags_w == $past(simd_flags_w))
      else $error("stack event touched vector flags");

   AST_RESP_FIELDS: assert property (
      req_i.valid |=> res_o.valid && res_o.sign == $past(req_i.sign) &&
      res_o.unit == $past(req_i.unit))
      else $error("response fields not carried");
   AST_NO_SPURIOUS: assert property (
      !req_i.valid |=> !res_o.valid && !res_o.handler && res_o.kind == fpcx_pkg::KIND_NONE)
      else $error("response without request");
endmodule : fpcx_unit
`default_nettype wire

// >>> sim/fpcx_dpath_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpcx_dpath_model (
   input wire logic mclk_i,
   output var fpcx_pkg::fpcx_req_s req_o
);
   initial req_o = '0;

   // One valid pulse per completed instruction
   task automatic issue(input fpcx_pkg::fpcx_req_s r);
      fpcx_pkg::fpcx_req_s q;
      q = ~r;
      q.valid = 1'b0;
      @(posedge mclk_i);
      req_o <= r;
      @(posedge mclk_i);
      // Stale fields inverted so nothing relies on them once valid drops
      req_o <= q;
   endtask : issue
endmodule : fpcx_dpath_model
`default_nettype wire

// >>> sim/fpcx_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
   checks++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("Error t=%0t got %h exp %h", $time, (g), (e)); \
   end \
end
module fpcx_unit_tb_top;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic pready_o;
   logic pslverr_o;
   logic [31:0] prdata_o;
   fpcx_pkg::fpcx_req_s req;
   fpcx_pkg::fpcx_res_s res_o;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   int ovf_e[3] = '{128, 1024, 16384};
   int tiny_e[3] = '{-126, -1022, -16382};
   logic [31:0] rdat;
   logic rerr;

   initial forever #4 mclk_i = ~mclk_i;

   fpcx_unit u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .req_i(req), .res_o(res_o));
   fpcx_dpath_model u_dp (.mclk_i(mclk_i), .req_o(req));

   task automatic test_done();
      $display("Checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   // Hang guard well above the roughly 170 cycles the sequence needs
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         test_done();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      `CHK(rdat, e)
      `CHK(rerr, 1'b0)
   endtask : rd

   function automatic fpcx_pkg::fpcx_req_s mk(input logic u, input logic [1:0] f,
      input logic [1:0] m, input logic s, input logic z, input logic x, input logic dm,
      input int e);
      fpcx_pkg::fpcx_req_s r;
      r.valid = 1'b1;
      r.unit = fpcx_pkg::fpcx_unit_e'(u);
      r.fmt = fpcx_pkg::fpcx_fmt_e'(f);
      r.rmode = fpcx_pkg::fpcx_rmode_e'(m);
      r.sign = s;
      r.zero = z;
      r.inexact = x;
      r.dest_mem = dm;
      r.exp = 18'(e);
      return r;
   endfunction : mk

   function automatic fpcx_pkg::fpcx_kind_e ovk(input int m, input logic s);
      case (m)
         0: return fpcx_pkg::KIND_INF;
         1: return s ? fpcx_pkg::KIND_INF : fpcx_pkg::KIND_MAX_FINITE;
         2: return s ? fpcx_pkg::KIND_MAX_FINITE : fpcx_pkg::KIND_INF;
         default: return fpcx_pkg::KIND_MAX_FINITE;
      endcase
   endfunction : ovk

   task automatic op(input fpcx_pkg::fpcx_req_s r, input fpcx_pkg::fpcx_kind_e k,
      input logic h);
      u_dp.issue(r);
      #1;
      `CHK(res_o.valid, 1'b1)
      `CHK(res_o.kind, k)
      `CHK(res_o.handler, h)
      `CHK(res_o.sign, r.sign)
      `CHK(res_o.unit, r.unit)
   endtask : op

   initial begin
      repeat (12) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rd(12'h000, 32'h00000000);
      rd(12'h004, 32'h0000003F);
      rd(12'h008, 32'h00001F80);
      apb(1'b0, 12'h00C, 32'h00000000);
      `CHK(rdat, 32'h00000000)
      `CHK(rerr, 1'b1)
      for (int f = 0; f < 3; f++) begin
         op(mk(0, f, 0, 1, 0, 0, 0, tiny_e[f] - 1), fpcx_pkg::KIND_DENORM, 0);
         op(mk(0, f, 0, 0, 0, 0, 0, tiny_e[f]), fpcx_pkg::KIND_ROUNDED, 0);
         op(mk(0, f, 0, 0, 0, 0, 0, ovf_e[f] - 1), fpcx_pkg::KIND_ROUNDED, 0);
      end
      rd(12'h000, 32'h00000000);
      for (int f = 0; f < 3; f++) begin
         for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
               op(mk(0, f, m, s, 0, 1, 0, ovf_e[f]), ovk(m, s), 0);
            end
         end
      end
      rd(12'h000, 32'h00000028);
      op(mk(0, 1, 0, 0, 0, 1, 0, tiny_e[1] - 5), fpcx_pkg::KIND_DENORM, 0);
      rd(12'h000, 32'h00000038);
      apb(1'b1, 12'h000, 32'h00000000);
      rd(12'h000, 32'h00000000);
      apb(1'b1, 12'h004, 32'h00000000);
      op(mk(0, 0, 1, 0, 0, 1, 0, ovf_e[0]), fpcx_pkg::KIND_BIASED, 1);
      rd(12'h000, 32'h00000028);
      apb(1'b1, 12'h000, 32'h00000000);
      op(mk(0, 2, 0, 1, 0, 1, 1, ovf_e[2] + 3), fpcx_pkg::KIND_BIASED, 1);
      rd(12'h000, 32'h00000008);
      apb(1'b1, 12'h000, 32'h00000000);
      op(mk(0, 0, 0, 0, 0, 0, 0, tiny_e[0] - 1), fpcx_pkg::KIND_BIASED, 1);
      op(mk(0, 0, 0, 0, 0, 1, 0, 0), fpcx_pkg::KIND_ROUNDED, 1);
      op(mk(0, 0, 0, 0, 1, 0, 0, ovf_e[0]), fpcx_pkg::KIND_ROUNDED, 0);
      rd(12'h000, 32'h00000030);
      apb(1'b1, 12'h004, 32'h0000003F);
      op(mk(0, 0, 0, 0, 0, 1, 0, 0), fpcx_pkg::KIND_ROUNDED, 0);
      apb(1'b1, 12'h008, 32'h00001FC0);
      rd(12'h008, 32'h00001F80);
      apb(1'b1, 12'h008, 32'h00000000);
      op(mk(1, 1, 0, 0, 0, 0, 0, ovf_e[1]), fpcx_pkg::KIND_NONE, 1);
      op(mk(1, 1, 0, 0, 0, 0, 0, tiny_e[1] - 1), fpcx_pkg::KIND_NONE, 1);
      rd(12'h008, 32'h00000018);
      apb(1'b1, 12'h008, 32'h00000F80);
      op(mk(1, 0, 0, 1, 0, 1, 0, ovf_e[0]), fpcx_pkg::KIND_INF, 1);
      rd(12'h008, 32'h00000FA8);
      rd(12'h000, 32'h00000030);
      test_done();
   end
endmodule : fpcx_unit_tb_top
`default_nettype wire
